// [scpd_pkg.sv]
// constants for the status pin clock divider block
package scpd_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_ROUTE   = 8'h2d;
  localparam logic [7:0] IDX_DIV0    = 8'h2e;
  localparam logic [7:0] IDX_DIV1    = 8'h2f;
  localparam logic [7:0] IDX_SWRST   = 8'h30;
  localparam logic [7:0] IDX_STATE   = 8'h31;
  localparam int         ADDR_W      = 12;
  localparam logic [11:0] ADDR_ROUTE = {2'b00, IDX_ROUTE, 2'b00};
  localparam logic [11:0] ADDR_DIV0  = {2'b00, IDX_DIV0, 2'b00};
  localparam logic [11:0] ADDR_DIV1  = {2'b00, IDX_DIV1, 2'b00};
  localparam logic [11:0] ADDR_SWRST = {2'b00, IDX_SWRST, 2'b00};
  localparam logic [11:0] ADDR_STATE = {2'b00, IDX_STATE, 2'b00};
  // ==========================================================
  // route control fields
  localparam int PRE_B_LSB = 6;
  localparam int PRE_A_LSB = 4;
  localparam int PIN_B_LSB = 2;
  localparam int PIN_A_LSB = 0;
  localparam int SWRST_BIT = 0;
  localparam logic [7:0] ROUTE_RST = 8'h0a;
  localparam logic [7:0] DIV_RST   = 8'h00;
  // ==========================================================
  // encodings
  localparam logic [1:0] PRE_OFF  = 2'h0;
  localparam logic [1:0] PRE_BY4  = 2'h1;
  localparam logic [1:0] PRE_BY5  = 2'h2;
  localparam logic [1:0] PIN_DIV0 = 2'h0;
  localparam logic [1:0] PIN_DIV1 = 2'h1;
  localparam logic [1:0] PIN_STAT = 2'h2;
  localparam logic [1:0] PIN_OFF  = 2'h3;
  localparam logic [8:0] RATIO_OFF  = 9'h000;
  localparam logic [8:0] RATIO_FOUR = 9'h004;
  localparam logic [8:0] RATIO_FIVE = 9'h005;
  localparam logic [8:0] RATIO_MIN  = 9'h006;
  localparam logic [7:0] CODE_MINLIN = 8'h06;
endpackage : scpd_pkg

// [scpd_div_if.sv]
// carrier between the top and one counting divider
`timescale 1ns/1ps
interface scpd_div_if;
  logic [8:0] ratio;
  logic       tick_in;
  logic       restart;
  logic       tick_out;
  logic       clk_lvl;
  modport div (input ratio, input tick_in, input restart, output tick_out, output clk_lvl);
  modport ctl (output ratio, output tick_in, output restart, input tick_out, input clk_lvl);
endinterface : scpd_div_if

// [scpd_divider.sv]
// one counting divider: ratio 0 halts, else one output tick per ratio input ticks
`timescale 1ns/1ps
module scpd_divider (
  input  wire logic mclk,
  input  wire logic rst,
  scpd_div_if.div   d
);
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic       lvl_r;
  logic       lvl_nxt;
  logic       wrap;

  assign wrap       = d.tick_in && (d.ratio != scpd_pkg::RATIO_OFF) && !d.restart
                      && (cnt_r >= d.ratio - 9'h001);
  assign d.tick_out = wrap;
  assign d.clk_lvl  = lvl_r;

  always_comb begin
    cnt_nxt = cnt_r;
    lvl_nxt = lvl_r;
    if (d.restart || d.ratio == scpd_pkg::RATIO_OFF) begin
      cnt_nxt = 9'h000;
      lvl_nxt = 1'b0;
    end else if (d.tick_in) begin
      cnt_nxt = wrap ? 9'h000 : cnt_r + 9'h001;
      // high for the first half of each output period
      lvl_nxt = (cnt_nxt < {1'b0, d.ratio[8:1]});
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 9'h000;
      lvl_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  halt_low_a: assert property (@(posedge mclk) disable iff (rst)
    (d.ratio == scpd_pkg::RATIO_OFF) |=> !lvl_r && cnt_r == 9'h000)
    else $error("halted divider still running");
  // a ratio lowered on the fly may leave the count above the new end, so check the wrap
  // at the exact end count and the restart from zero after it
  wrap_count_a: assert property (@(posedge mclk) disable iff (rst)
    (d.tick_in && !d.restart && d.ratio != scpd_pkg::RATIO_OFF && cnt_r == d.ratio - 9'h001)
      |-> d.tick_out ##1 cnt_r == 9'h000)
    else $error("divider wrapped at wrong count");
endmodule : scpd_divider

// [scpd_top.sv]
// status pin clock routing and division with APB registers
`timescale 1ns/1ps
module scpd_top (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        synth_a_tick,
  input  wire logic        synth_b_tick,
  input  wire logic        status_a_in,
  input  wire logic        status_b_in,
  output logic             flag_pin_a,
  output logic             flag_pin_a_oe,
  output logic             flag_pin_b,
  output logic             flag_pin_b_oe
);
  // ==========================================================
  // code decoding
  function automatic logic [8:0] prescale_ratio(input logic [1:0] code);
    case (code)
      scpd_pkg::PRE_BY4: prescale_ratio = scpd_pkg::RATIO_FOUR;
      scpd_pkg::PRE_BY5: prescale_ratio = scpd_pkg::RATIO_FIVE;
      // reserved code treated as off
      default:           prescale_ratio = scpd_pkg::RATIO_OFF;
    endcase
  endfunction : prescale_ratio

  function automatic logic [8:0] out_ratio(input logic [7:0] code, input logic run);
    if (!run || code == 8'h00) begin
      out_ratio = scpd_pkg::RATIO_OFF;
    end else if (code < scpd_pkg::CODE_MINLIN) begin
      out_ratio = scpd_pkg::RATIO_MIN;
    end else begin
      out_ratio = {1'b0, code} + 9'h001;
    end
  endfunction : out_ratio

  function automatic logic pin_mux(input logic [1:0] sel, input logic c0,
                                   input logic c1, input logic st);
    case (sel)
      scpd_pkg::PIN_DIV0: pin_mux = c0;
      scpd_pkg::PIN_DIV1: pin_mux = c1;
      scpd_pkg::PIN_STAT: pin_mux = st;
      default:            pin_mux = 1'b0;
    endcase
  endfunction : pin_mux

  // ==========================================================
  // registers
  logic [7:0]  route_r, route_nxt;
  logic [7:0]  div0_r, div0_nxt;
  logic [7:0]  div1_r, div1_nxt;
  logic        run0_r, run0_nxt;
  logic        run1_r, run1_nxt;
  logic        restart_r, restart_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pa_r, pa_nxt, pa_oe_r, pa_oe_nxt;
  logic        pb_r, pb_nxt, pb_oe_r, pb_oe_nxt;
  logic        wr_en, setup, hit;
  logic [1:0]  sel_pre_a, sel_pre_b, sel_pin_a, sel_pin_b;

  scpd_div_if pre_a ();
  scpd_div_if pre_b ();
  scpd_div_if odiv0 ();
  scpd_div_if odiv1 ();

  assign sel_pre_b = route_r[scpd_pkg::PRE_B_LSB +: 2];
  assign sel_pre_a = route_r[scpd_pkg::PRE_A_LSB +: 2];
  assign sel_pin_b = route_r[scpd_pkg::PIN_B_LSB +: 2];
  assign sel_pin_a = route_r[scpd_pkg::PIN_A_LSB +: 2];

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  assign hit = (paddr == scpd_pkg::ADDR_ROUTE) || (paddr == scpd_pkg::ADDR_DIV0)
            || (paddr == scpd_pkg::ADDR_DIV1) || (paddr == scpd_pkg::ADDR_SWRST)
            || (paddr == scpd_pkg::ADDR_STATE);
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_r;

  always_comb begin
    route_nxt   = route_r;
    div0_nxt    = div0_r;
    div1_nxt    = div1_r;
    run0_nxt    = run0_r;
    run1_nxt    = run1_r;
    restart_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    if (wr_en) begin
      if (paddr == scpd_pkg::ADDR_ROUTE) begin
        route_nxt = pwdata[7:0];
      end else if (paddr == scpd_pkg::ADDR_DIV0) begin
        div0_nxt = pwdata[7:0];
        // a zero halts until the next soft reset
        if (pwdata[7:0] == 8'h00) run0_nxt = 1'b0;
      end else if (paddr == scpd_pkg::ADDR_DIV1) begin
        div1_nxt = pwdata[7:0];
        if (pwdata[7:0] == 8'h00) run1_nxt = 1'b0;
      end else if (paddr == scpd_pkg::ADDR_SWRST) begin
        if (pwdata[scpd_pkg::SWRST_BIT]) begin
          restart_nxt = 1'b1;
          run0_nxt    = 1'b1;
          run1_nxt    = 1'b1;
        end
      end
    end
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      if (paddr == scpd_pkg::ADDR_ROUTE) begin
        prdata_nxt[7:0] = route_r;
      end else if (paddr == scpd_pkg::ADDR_DIV0) begin
        prdata_nxt[7:0] = div0_r;
      end else if (paddr == scpd_pkg::ADDR_DIV1) begin
        prdata_nxt[7:0] = div1_r;
      end else if (paddr == scpd_pkg::ADDR_STATE) begin
        prdata_nxt[5:0] = {run1_r, run0_r, pb_r, pa_r, odiv1.clk_lvl, odiv0.clk_lvl};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      route_r   <= scpd_pkg::ROUTE_RST;
      div0_r    <= scpd_pkg::DIV_RST;
      div1_r    <= scpd_pkg::DIV_RST;
      run0_r    <= 1'b0;
      run1_r    <= 1'b0;
      restart_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      route_r   <= route_nxt;
      div0_r    <= div0_nxt;
      div1_r    <= div1_nxt;
      run0_r    <= run0_nxt;
      run1_r    <= run1_nxt;
      restart_r <= restart_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ==========================================================
  // divider chain
  assign pre_a.ratio   = prescale_ratio(sel_pre_a);
  assign pre_a.tick_in = synth_a_tick;
  assign pre_a.restart = restart_r;
  assign pre_b.ratio   = prescale_ratio(sel_pre_b);
  assign pre_b.tick_in = synth_b_tick;
  assign pre_b.restart = restart_r;
  assign odiv0.ratio   = out_ratio(div0_r, run0_r);
  assign odiv0.tick_in = pre_a.tick_out;
  assign odiv0.restart = restart_r;
  assign odiv1.ratio   = out_ratio(div1_r, run1_r);
  assign odiv1.tick_in = pre_b.tick_out;
  assign odiv1.restart = restart_r;

  scpd_divider u_pre_a (.mclk(mclk), .rst(rst), .d(pre_a.div));
  scpd_divider u_pre_b (.mclk(mclk), .rst(rst), .d(pre_b.div));
  scpd_divider u_div0  (.mclk(mclk), .rst(rst), .d(odiv0.div));
  scpd_divider u_div1  (.mclk(mclk), .rst(rst), .d(odiv1.div));

  // ==========================================================
  // pin multiplexers, registered
  always_comb begin
    pa_nxt    = pin_mux(sel_pin_a, odiv0.clk_lvl, odiv1.clk_lvl, status_a_in);
    pa_oe_nxt = (sel_pin_a != scpd_pkg::PIN_OFF);
    pb_nxt    = pin_mux(sel_pin_b, odiv0.clk_lvl, odiv1.clk_lvl, status_b_in);
    pb_oe_nxt = (sel_pin_b != scpd_pkg::PIN_OFF);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pa_r    <= 1'b0;
      pa_oe_r <= 1'b1;
      pb_r    <= 1'b0;
      pb_oe_r <= 1'b1;
    end else begin
      pa_r    <= pa_nxt;
      pa_oe_r <= pa_oe_nxt;
      pb_r    <= pb_nxt;
      pb_oe_r <= pb_oe_nxt;
    end
  end

  assign flag_pin_a    = pa_r;
  assign flag_pin_a_oe = pa_oe_r;
  assign flag_pin_b    = pb_r;
  assign flag_pin_b_oe = pb_oe_r;

  // ==========================================================
  // checks
  reserved_pre_a: assert property (@(posedge mclk) disable iff (rst)
    (sel_pre_a == 2'h3 || sel_pre_b == 2'h3) |-> !(sel_pre_a == 2'h3 && pre_a.tick_out)
      && !(sel_pre_b == 2'h3 && pre_b.tick_out))
    else $error("reserved prescale code produced a tick");
  pin_a_route_a: assert property (@(posedge mclk) disable iff (rst)
    (sel_pin_a == scpd_pkg::PIN_DIV1) |=> (flag_pin_a == $past(odiv1.clk_lvl)) && flag_pin_a_oe)
    else $error("pin a not following divider one");
  pin_b_route_a: assert property (@(posedge mclk) disable iff (rst)
    (sel_pin_b == scpd_pkg::PIN_STAT) |=> (flag_pin_b == $past(status_b_in)))
    else $error("pin b not carrying status");
  pin_off_a: assert property (@(posedge mclk) disable iff (rst)
    (sel_pin_b == scpd_pkg::PIN_OFF) |=> !flag_pin_b_oe)
    else $error("disabled pin b still driven");
  zero_halts_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_en && paddr == scpd_pkg::ADDR_DIV0 && pwdata[7:0] == 8'h00)
      |=> !run0_r && odiv0.ratio == scpd_pkg::RATIO_OFF)
    else $error("divider zero not halted by zero write");
  soft_restart_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_en && paddr == scpd_pkg::ADDR_SWRST && pwdata[0]) |=> restart_r && run0_r ##1 !restart_r)
    else $error("soft reset pulse wrong");
  small_code_a: assert property (@(posedge mclk) disable iff (rst)
    (run0_r && div0_r != 8'h00 && div0_r < 8'h06) |-> odiv0.ratio == 9'h006)
    else $error("small code not dividing by six");
endmodule : scpd_top

// [scpd_top_tb_top.sv]
// self-checking bench for the status pin clock divider
`timescale 1ns/1ps
module scpd_top_tb_top;
  // ==========================================================
  // stimulus and bookkeeping
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        synth_a_tick = 1'b0;
  logic        synth_b_tick = 1'b0;
  logic        status_a_in = 1'b0;
  logic        status_b_in = 1'b0;
  logic        flag_pin_a;
  logic        flag_pin_a_oe;
  logic        flag_pin_b;
  logic        flag_pin_b_oe;
  logic [2:0]  tk = 3'h0;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #50 mclk = ~mclk;

  // synth a ticks every 2 cycles, synth b every 3, so the source shows in the period
  always @(posedge mclk) begin
    tk <= (tk == 3'h5) ? 3'h0 : tk + 3'h1;
    synth_a_tick <= tk[0];
    synth_b_tick <= (tk == 3'h2) || (tk == 3'h5);
  end

  scpd_top dut_u (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .synth_a_tick(synth_a_tick), .synth_b_tick(synth_b_tick),
    .status_a_in(status_a_in), .status_b_in(status_b_in),
    .flag_pin_a(flag_pin_a), .flag_pin_a_oe(flag_pin_a_oe),
    .flag_pin_b(flag_pin_b), .flag_pin_b_oe(flag_pin_b_oe)
  );

  // ==========================================================
  // reporting
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_per(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      bad_count++;
      $display("[ERR] t=%0t period got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_per

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // apb master: request held until pready is seen at a rising edge
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                          output logic [31:0] rd, output logic er);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait-state count assumed: only the bench timeout ends this wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb_xfer(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        er;
    apb_xfer(1'b0, a, 32'h0000_0000, rd, er);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, experr});
  endtask : rdchk

  function automatic logic [31:0] pins();
    return {28'h0, flag_pin_b_oe, flag_pin_b, flag_pin_a_oe, flag_pin_a};
  endfunction : pins

  // rising edge to rising edge on one pin; 0 when it does not toggle in the window
  task automatic period(input logic sb, output int per);
    logic prev = 1'b1;
    logic cur;
    int   e = 0;
    int   t0 = 0;
    per = 0;
    // sampled mid-cycle, where the registered pin has settled
    for (int n = 0; n < 600 && e < 3; n++) begin
      @(negedge mclk);
      cur = sb ? flag_pin_b : flag_pin_a;
      if (cur === 1'b1 && prev === 1'b0) begin
        e++;
        if (e == 2) t0 = n;
        if (e == 3) per = n - t0;
      end
      prev = cur;
    end
  endtask : period

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdchk(scpd_pkg::ADDR_ROUTE, 32'h0000_000a, 1'b0);
    rdchk(scpd_pkg::ADDR_DIV0, 32'h0000_0000, 1'b0);
    rdchk(scpd_pkg::ADDR_DIV1, 32'h0000_0000, 1'b0);
    rdchk(12'h000, 32'h0000_0000, 1'b1);
    @(posedge mclk);
    status_a_in <= 1'b1;
    repeat (3) @(negedge mclk);
    chk(pins(), 32'h0000_000b);
    @(posedge mclk);
    status_a_in <= 1'b0;
    status_b_in <= 1'b1;
    repeat (3) @(negedge mclk);
    chk(pins(), 32'h0000_000e);
    rdchk(scpd_pkg::ADDR_STATE, 32'h0000_0008, 1'b0);
    wr(scpd_pkg::ADDR_ROUTE, 32'hffff_ff0f);
    rdchk(scpd_pkg::ADDR_ROUTE, 32'h0000_000f, 1'b0);
    repeat (3) @(negedge mclk);
    chk(pins(), 32'h0000_0000);
  endtask : t_reset

  task automatic t_div_a;
    int codes[3] = '{1, 5, 6};
    int per;
    int r;
    wr(scpd_pkg::ADDR_DIV0, 32'h0000_0001);
    wr(scpd_pkg::ADDR_SWRST, 32'h0000_0001);
    for (int p = 1; p <= 2; p++) begin
      for (int k = 0; k < 3; k++) begin
        r = (codes[k] < 6) ? 6 : codes[k] + 1;
        wr(scpd_pkg::ADDR_ROUTE, {24'h0, 2'b00, p[1:0], 4'h8});
        wr(scpd_pkg::ADDR_DIV0, codes[k]);
        period(1'b0, per);
        chk_per(per, 2 * (p + 3) * r);
      end
    end
  endtask : t_div_a

  task automatic t_div_b;
    int per;
    wr(scpd_pkg::ADDR_DIV1, 32'h0000_0007);
    wr(scpd_pkg::ADDR_SWRST, 32'h0000_0001);
    for (int p = 1; p <= 2; p++) begin
      wr(scpd_pkg::ADDR_ROUTE, {24'h0, p[1:0], 6'h05});
      period(1'b1, per);
      chk_per(per, 3 * (p + 3) * 8);
      period(1'b0, per);
      chk_per(per, 3 * (p + 3) * 8);
    end
    wr(scpd_pkg::ADDR_ROUTE, 32'h0000_00f4);
    period(1'b0, per);
    chk_per(per, 0);
    period(1'b1, per);
    chk_per(per, 0);
  endtask : t_div_b

  task automatic t_soft_reset;
    int          per;
    logic [31:0] rd;
    logic        er;
    wr(scpd_pkg::ADDR_ROUTE, 32'h0000_0010);
    wr(scpd_pkg::ADDR_DIV0, 32'h0000_0000);
    wr(scpd_pkg::ADDR_DIV0, 32'h0000_0006);
    period(1'b0, per);
    chk_per(per, 0);
    apb_xfer(1'b0, scpd_pkg::ADDR_STATE, 32'h0000_0000, rd, er);
    chk({31'h0, rd[4]}, 32'h0000_0000);
    wr(scpd_pkg::ADDR_SWRST, 32'h0000_0001);
    period(1'b0, per);
    chk_per(per, 56);
    period(1'b1, per);
    chk_per(per, 56);
    apb_xfer(1'b0, scpd_pkg::ADDR_STATE, 32'h0000_0000, rd, er);
    chk({30'h0, rd[5:4]}, 32'h0000_0003);
    rdchk(scpd_pkg::ADDR_SWRST, 32'h0000_0000, 1'b0);
  endtask : t_soft_reset

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_div_a();
    t_div_b();
    t_soft_reset();
    tally_and_finish();
  end
endmodule : scpd_top_tb_top
